// ==== hdl/fpsc_top.sv ====
// fft processor status/control register bank with its data buffer and sequencer
// assumes the bridge issues at most one read or write per clock, synchronous to i_sys_clk
`timescale 1ns/100ps

module fpsc_buf #(
  parameter int W = 32,
  parameter int D = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // fill side
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  input wire logic i_out_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] DEPTH = (AW + 1)'(D);
  localparam logic [AW-1:0] LAST_IDX = AW'(D - 1);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  logic full_ff;
  logic push;
  logic pop;
  logic [AW:0] nxt_cnt;

  assign push = i_in_valid && !full_ff;
  assign pop = i_out_ready && (cnt_ff != '0);
  assign nxt_cnt = cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
  assign o_in_ready = !full_ff;
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem_ff[rp_ff];

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      full_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      full_ff <= (nxt_cnt == DEPTH);
      if (push)
        wp_ff <= (wp_ff == LAST_IDX) ? '0 : wp_ff + AW'(1);
      if (pop)
        rp_ff <= (rp_ff == LAST_IDX) ? '0 : rp_ff + AW'(1);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_ff[wp_ff] <= i_in_data;
  end
endmodule

// Notes on behaviour
// - over-range mask bit resets to 1; clearing it lets over-range interrupt
// - cycle, phase, not-empty, underflow, overflow mask bits reset to 1; 0 enables
// - sticky status flags at bits 0,1,2,5,6,8, all reset to 0
// - flags record events whatever the mask says
// - flags clear only by reset or writing 1; writing 0 keeps them
// - every status write forces the interrupt line high for a cycle
// - interrupt line low while any flag is set with its mask clear
// - cycle done waits until the cycle's final word entered the fifo
// - last cycle end clears running with cycle and phase flags set together
// - fifo condition bit 16 reads 1 when the fifo is empty
// - phases per cycle is 24-bit read/write, resets 0, phases minus one
// - phases per cycle changes apply from the next processing cycle
// - cycle progress bits 23:0 hold remaining cycles minus one, read-only
// - cycle progress bits 30:24 hold mode captured at cycle start
// - phase progress bits 23:0 hold remaining phases minus one, read-only
// - cycles to run is 24-bit read/write, resets 0, loaded at start
// - sampler bit 0 picks clock source, resets 1, 1 is internal oscillator
// - sampler bits 3:1 pick divider code, reset to 7
// - sampler bit 7 drives sampler reset level directly, resets 0
// - global reset also sends a reset pulse to the sampler frontend
// - each fifo port read of a non-empty fifo returns and removes the next word, burst capable
module fpsc_top (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // local bus from the bridge
  input wire fpsc_pkg::fpsc_bus_req_type i_bus,
  output logic [31:0] o_lb_rdata,
  output logic o_lb_rvalid,
  // datapath data words and events
  input wire fpsc_pkg::fpsc_dp_word_type i_dp,
  output logic o_dp_ready,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic i_phase_done,
  input wire logic i_over_range,
  input wire logic [fpsc_pkg::MODE_W-1:0] i_mode_select,
  input wire logic [fpsc_pkg::CLK_OK_W-1:0] i_clk_ok,
  // host interrupt and status
  output logic o_host_interrupt_n,
  output logic o_processing_active,
  // sampler frontend
  output logic o_clk_src_internal,
  output logic [2:0] o_clk_div_code,
  output logic o_sampler_non_interleave,
  output logic o_sampler_reset
);
  fpsc_pkg::fpsc_state_type state_ff;
  logic [31:0] mask_ff;
  logic [31:0] flags_ff;
  logic [31:0] nxt_flags;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [fpsc_pkg::CNT_W-1:0] phases_ff;
  logic [fpsc_pkg::CNT_W-1:0] cycles_ff;
  logic [fpsc_pkg::CNT_W-1:0] ph_left_ff;
  logic [fpsc_pkg::CNT_W-1:0] cyc_left_ff;
  logic [fpsc_pkg::MODE_W-1:0] mode_cap_ff;
  logic [7:0] smp_ff;
  logic [fpsc_pkg::CLK_OK_W-1:0] clk_ok_ff;
  logic [6:0] smp_pulse_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic rvalid_ff;
  logic irq_n_ff;
  logic dp_ready_ff;
  logic was_valid_ff;
  logic seen_last_ff;
  logic active_ff;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [fpsc_pkg::DATA_W-1:0] buf_out_data;
  logic wr_mask;
  logic wr_flags;
  logic rd_port;
  logic pop;
  logic push_ok;
  logic last_push;
  logic last_in;
  logic phase_end;
  logic cycle_end;

  assign wr_mask = i_bus.wr && (i_bus.addr == fpsc_pkg::ADDR_INT_MASK);
  assign wr_flags = i_bus.wr && (i_bus.addr == fpsc_pkg::ADDR_INT_FLAGS);
  assign rd_port = i_bus.rd && (i_bus.addr == fpsc_pkg::ADDR_FIFO_PORT);
  assign pop = rd_port && buf_out_valid;
  assign push_ok = i_dp.valid && buf_in_ready;
  assign last_push = push_ok && i_dp.last;
  assign last_in = seen_last_ff || last_push;
  assign phase_end = (state_ff == fpsc_pkg::ST_RUN) && i_phase_done;
  // the final phase only completes once the closing word sits in the fifo
  assign cycle_end = ((phase_end && ph_left_ff == '0) || state_ff == fpsc_pkg::ST_DRAIN)
                     && last_in;

  // the buffer drains one word per read, so back-to-back burst reads are served
  fpsc_buf #(
    .W(fpsc_pkg::DATA_W),
    .D(fpsc_pkg::BUF_DEPTH)
  ) u_data_buf (
    .i_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_in_valid(i_dp.valid),
    .i_in_data(i_dp.data),
    .o_in_ready(buf_in_ready),
    .i_out_ready(rd_port),
    .o_out_valid(buf_out_valid),
    .o_out_data(buf_out_data)
  );

  always_comb
  begin
    set_vec = '0;
    set_vec[fpsc_pkg::FLG_CYCLE] = cycle_end;
    set_vec[fpsc_pkg::FLG_PHASE] = (phase_end && ph_left_ff != '0) || cycle_end;
    set_vec[fpsc_pkg::FLG_FIFO_NOT_EMPTY_FLAG] = buf_out_valid && !was_valid_ff;
    set_vec[fpsc_pkg::FLG_UNDER] = rd_port && !buf_out_valid;
    set_vec[fpsc_pkg::FLG_OVER] = i_dp.valid && !buf_in_ready;
    set_vec[fpsc_pkg::FLG_RANGE] = i_over_range;
    clr_vec = wr_flags ? i_bus.wdata : '0;
    // set wins over a simultaneous write-one clear
    nxt_flags = ((flags_ff & ~clr_vec) | set_vec) & fpsc_pkg::INT_BITS;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      flags_ff <= fpsc_pkg::FLAGS_RESET;
      was_valid_ff <= 1'b0;
    end
    else
    begin
      flags_ff <= nxt_flags;
      was_valid_ff <= buf_out_valid;
    end
  end

  // interrupt line, released for one cycle on every status write for edge re-arm
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
      irq_n_ff <= 1'b1;
    else if (wr_flags)
      irq_n_ff <= 1'b1;
    else
      irq_n_ff <= ~|(flags_ff & ~mask_ff);
  end

  // software settings
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      mask_ff <= fpsc_pkg::MASK_RESET;
      phases_ff <= fpsc_pkg::CNT_RESET;
      cycles_ff <= fpsc_pkg::CNT_RESET;
      smp_ff <= fpsc_pkg::SMP_RESET;
    end
    else if (i_bus.wr)
    begin
      if (wr_mask)
        mask_ff <= (i_bus.wdata & fpsc_pkg::INT_BITS) | ~fpsc_pkg::INT_BITS;
      if (i_bus.addr == fpsc_pkg::ADDR_PHASES)
        phases_ff <= i_bus.wdata[fpsc_pkg::CNT_W-1:0];
      if (i_bus.addr == fpsc_pkg::ADDR_CYCLES)
        cycles_ff <= i_bus.wdata[fpsc_pkg::CNT_W-1:0];
      if (i_bus.addr == fpsc_pkg::ADDR_SAMPLER)
        smp_ff <= (i_bus.wdata[7:0] & fpsc_pkg::SMP_WBITS) | fpsc_pkg::SMP_FIXED;
    end
  end

  // processing sequencer
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      state_ff <= fpsc_pkg::ST_IDLE;
      ph_left_ff <= fpsc_pkg::CNT_RESET;
      cyc_left_ff <= fpsc_pkg::CNT_RESET;
      mode_cap_ff <= fpsc_pkg::MODE_RESET;
      seen_last_ff <= 1'b0;
      active_ff <= 1'b0;
    end
    else if (i_abort)
    begin
      state_ff <= fpsc_pkg::ST_IDLE;
      seen_last_ff <= 1'b0;
      active_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        fpsc_pkg::ST_IDLE:
        begin
          seen_last_ff <= 1'b0;
          if (i_start)
          begin
            state_ff <= fpsc_pkg::ST_RUN;
            active_ff <= 1'b1;
            cyc_left_ff <= cycles_ff;
            ph_left_ff <= phases_ff;
            mode_cap_ff <= i_mode_select;
          end
        end
        fpsc_pkg::ST_RUN, fpsc_pkg::ST_DRAIN:
        begin
          if (last_push)
            seen_last_ff <= 1'b1;
          if (cycle_end)
          begin
            seen_last_ff <= 1'b0;
            if (cyc_left_ff == '0)
            begin
              state_ff <= fpsc_pkg::ST_IDLE;
              active_ff <= 1'b0;
            end
            else
            begin
              state_ff <= fpsc_pkg::ST_RUN;
              cyc_left_ff <= cyc_left_ff - 24'h00_0001;
              ph_left_ff <= phases_ff;
              mode_cap_ff <= i_mode_select;
            end
          end
          else if (phase_end && ph_left_ff == '0)
            state_ff <= fpsc_pkg::ST_DRAIN;
          else if (phase_end)
            ph_left_ff <= ph_left_ff - 24'h00_0001;
        end
        default:
        begin
          state_ff <= fpsc_pkg::ST_IDLE;
          active_ff <= 1'b0;
        end
      endcase
    end
  end

  // sampler reset: level from software, stretched pulse after any global reset
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
      smp_pulse_ff <= fpsc_pkg::SMP_PULSE_CNT;
    else if (smp_pulse_ff != '0)
      smp_pulse_ff <= smp_pulse_ff - 7'h01;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      o_sampler_reset <= 1'b1;
      o_clk_src_internal <= fpsc_pkg::SMP_RESET[fpsc_pkg::SMP_SRC];
      o_clk_div_code <= fpsc_pkg::SMP_RESET[fpsc_pkg::SMP_DIV_LO +: 3];
      o_sampler_non_interleave <= fpsc_pkg::SMP_RESET[fpsc_pkg::SMP_SAMPLER_NON_INTERLEAVE];
      clk_ok_ff <= '0;
    end
    else
    begin
      o_sampler_reset <= smp_ff[fpsc_pkg::SMP_RST] || (smp_pulse_ff != '0);
      o_clk_src_internal <= smp_ff[fpsc_pkg::SMP_SRC];
      o_clk_div_code <= smp_ff[fpsc_pkg::SMP_DIV_LO +: 3];
      o_sampler_non_interleave <= smp_ff[fpsc_pkg::SMP_SAMPLER_NON_INTERLEAVE];
      clk_ok_ff <= i_clk_ok;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    nxt_rdata = '0;
    case (i_bus.addr)
      fpsc_pkg::ADDR_INT_MASK: nxt_rdata = mask_ff;
      fpsc_pkg::ADDR_INT_FLAGS: nxt_rdata = flags_ff;
      fpsc_pkg::ADDR_FIFO_COND: nxt_rdata[fpsc_pkg::FIFO_EMPTY_BIT] = !buf_out_valid;
      fpsc_pkg::ADDR_PHASES: nxt_rdata[fpsc_pkg::CNT_W-1:0] = phases_ff;
      fpsc_pkg::ADDR_CYC_PROG: nxt_rdata[30:0] = {mode_cap_ff, cyc_left_ff};
      fpsc_pkg::ADDR_PH_PROG: nxt_rdata[fpsc_pkg::CNT_W-1:0] = ph_left_ff;
      fpsc_pkg::ADDR_CLK_HEALTH: nxt_rdata[fpsc_pkg::CLK_OK_W-1:0] = clk_ok_ff;
      fpsc_pkg::ADDR_CYCLES: nxt_rdata[fpsc_pkg::CNT_W-1:0] = cycles_ff;
      fpsc_pkg::ADDR_SAMPLER: nxt_rdata[7:0] = smp_ff;
      fpsc_pkg::ADDR_FIFO_PORT: nxt_rdata = pop ? buf_out_data : '0;
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
      dp_ready_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= i_bus.rd ? nxt_rdata : '0;
      rvalid_ff <= i_bus.rd;
      dp_ready_ff <= buf_in_ready;
    end
  end

  assign o_lb_rdata = rdata_ff;
  assign o_lb_rvalid = rvalid_ff;
  assign o_host_interrupt_n = irq_n_ff;
  // kept as its own flop so the running indicator is glitch-free at the pin
  assign o_processing_active = active_ff;
  // ready is a registered copy gated by the live buffer ready; a push on a just-freed slot waits one cycle
  assign o_dp_ready = dp_ready_ff && buf_in_ready;

  property p_flag_records;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    i_over_range |=> flags_ff[fpsc_pkg::FLG_RANGE];
  endproperty
  a_flag_records: assert property (p_flag_records) else $error("flag not recorded");

  property p_write_zero_keeps;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (wr_flags && flags_ff[fpsc_pkg::FLG_RANGE] && !i_bus.wdata[fpsc_pkg::FLG_RANGE])
      |=> flags_ff[fpsc_pkg::FLG_RANGE];
  endproperty
  a_write_zero_keeps: assert property (p_write_zero_keeps) else $error("flag lost");

  property p_rearm;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    wr_flags |=> o_host_interrupt_n;
  endproperty
  a_rearm: assert property (p_rearm) else $error("no rearm pulse");

  property p_irq_level;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (!wr_flags && |(flags_ff & ~mask_ff)) |=> !o_host_interrupt_n;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not asserted");

  property p_cycle_after_last;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(flags_ff[fpsc_pkg::FLG_CYCLE]) |-> $past(last_in);
  endproperty
  a_cycle_after_last: assert property (p_cycle_after_last) else $error("early cycle done");

  property p_last_cycle;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (cycle_end && cyc_left_ff == '0 && !i_abort) |=> (!o_processing_active
      && flags_ff[fpsc_pkg::FLG_CYCLE] && flags_ff[fpsc_pkg::FLG_PHASE]);
  endproperty
  a_last_cycle: assert property (p_last_cycle) else $error("end not atomic");

  property p_empty_bit;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (i_bus.rd && i_bus.addr == fpsc_pkg::ADDR_FIFO_COND && !buf_out_valid)
      |=> o_lb_rdata[fpsc_pkg::FIFO_EMPTY_BIT];
  endproperty
  a_empty_bit: assert property (p_empty_bit) else $error("empty bit wrong");

  property p_underflow;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (rd_port && !buf_out_valid) |=> flags_ff[fpsc_pkg::FLG_UNDER];
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow missed");

  property p_smp_pulse;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(i_resetn) |-> o_sampler_reset [*8];
  endproperty
  a_smp_pulse: assert property (p_smp_pulse) else $error("no sampler pulse");

  c_cycle_end: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) cycle_end);
  c_overflow: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_dp.valid && !buf_in_ready);
  c_irq: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) $fell(o_host_interrupt_n));
  c_burst: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) pop ##1 pop);
endmodule

// ==== hdl/fpsc_pkg.sv ====
// package for the fft processor status and control register bank
// assumes a single local bus clock at 40 MHz and a synchronous active-low reset
package fpsc_pkg;

  // register byte offsets on the local bus
  localparam logic [7:0] ADDR_INT_MASK = 8'h18;
  localparam logic [7:0] ADDR_INT_FLAGS = 8'h1c;
  localparam logic [7:0] ADDR_FIFO_COND = 8'h24;
  localparam logic [7:0] ADDR_PHASES = 8'h28;
  localparam logic [7:0] ADDR_CYC_PROG = 8'h2c;
  localparam logic [7:0] ADDR_PH_PROG = 8'h30;
  localparam logic [7:0] ADDR_CLK_HEALTH = 8'h34;
  localparam logic [7:0] ADDR_CYCLES = 8'h38;
  localparam logic [7:0] ADDR_SAMPLER = 8'h3c;
  localparam logic [7:0] ADDR_FIFO_PORT = 8'h80;

  // interrupt flag and mask bit positions
  localparam int FLG_CYCLE = 0;
  localparam int FLG_PHASE = 1;
  localparam int FLG_FIFO_NOT_EMPTY_FLAG = 2;
  localparam int FLG_UNDER = 5;
  localparam int FLG_OVER = 6;
  localparam int FLG_RANGE = 8;
  localparam logic [31:0] INT_BITS = 32'h0000_0167;
  localparam logic [31:0] MASK_RESET = 32'hffff_ffff;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;

  // fifo condition, counters and progress layout
  localparam int FIFO_EMPTY_BIT = 16;
  localparam int CNT_W = 24;
  localparam int MODE_W = 7;
  localparam logic [CNT_W-1:0] CNT_RESET = 24'h00_0000;
  localparam logic [MODE_W-1:0] MODE_RESET = 7'h00;
  localparam int CLK_OK_W = 3;

  // sampler control layout
  localparam int SMP_SRC = 0;
  localparam int SMP_DIV_LO = 1;
  localparam int SMP_SAMPLER_NON_INTERLEAVE = 5;
  localparam int SMP_RST = 7;
  localparam logic [7:0] SMP_RESET = 8'h7f;
  localparam logic [7:0] SMP_WBITS = 8'haf;
  localparam logic [7:0] SMP_FIXED = 8'h50;

  // data buffer geometry
  localparam int DATA_W = 32;
  localparam int BUF_DEPTH = 2;

  // sampler reset pulse after a global reset
  localparam int CLK_PERIOD_NS = 25;
  localparam int SMP_PULSE_NS = 1000;
  localparam int SMP_PULSE_CYC = (SMP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] SMP_PULSE_CNT = 7'(SMP_PULSE_CYC);

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } fpsc_bus_req_type;

  typedef struct packed {
    logic valid;
    logic last;
    logic [DATA_W-1:0] data;
  } fpsc_dp_word_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DRAIN = 3'b100
  } fpsc_state_type;

endpackage

// ==== dv/fpsc_bridge_model.sv ====
// local bus bridge model: single register reads and writes toward the bank
// assumes the bank samples its bus on the rising edge of i_sys_clk
`timescale 1ns/100ps
module fpsc_bridge_model (
  // clock
  input wire logic i_sys_clk,
  // bus toward the register bank
  output fpsc_pkg::fpsc_bus_req_type o_bus,
  input wire logic [31:0] i_lb_rdata,
  input wire logic i_lb_rvalid
);
  initial o_bus = '0;

  // released address and data show their inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_sys_clk);
    o_bus = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(negedge i_sys_clk);
    o_bus = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
  endtask

  // read data stands from the taking edge on, sampled half a cycle later at the next falling edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge i_sys_clk);
    o_bus = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
    @(negedge i_sys_clk);
    o_bus = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: 32'hffff_ffff};
    d = i_lb_rvalid === 1'h1 ? i_lb_rdata : 32'hx;
  endtask
endmodule

// ==== dv/fpsc_top_tb_top.sv ====
// self-checking testbench for the fft processor status and control register bank
// assumes the bridge model is the only master of the local bus
`timescale 1ns/100ps
module fpsc_top_tb_top;
  logic i_sys_clk = 1'h0;
  logic i_resetn = 1'h0;
  fpsc_pkg::fpsc_bus_req_type bus;
  fpsc_pkg::fpsc_dp_word_type dp = '0;
  logic start = 1'h0;
  logic abort = 1'h0;
  logic ph_done = 1'h0;
  logic over_range = 1'h0;
  logic [6:0] mode = 7'h05;
  logic [2:0] clk_ok = 3'h5;
  logic [31:0] rdata;
  logic rvalid, irq_n, active, clk_src, non_int, smp_rst, dp_ready;
  logic [2:0] div;
  int failures = 0;
  int n_compared = 0;

  initial
  begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  fpsc_top i_fpsc_top (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_bus(bus),
    .o_lb_rdata(rdata), .o_lb_rvalid(rvalid), .i_dp(dp), .o_dp_ready(dp_ready),
    .i_start(start), .i_abort(abort), .i_phase_done(ph_done), .i_over_range(over_range),
    .i_mode_select(mode), .i_clk_ok(clk_ok), .o_host_interrupt_n(irq_n),
    .o_processing_active(active), .o_clk_src_internal(clk_src), .o_clk_div_code(div),
    .o_sampler_non_interleave(non_int), .o_sampler_reset(smp_rst));
  fpsc_bridge_model i_fpsc_bridge_model (.i_sys_clk(i_sys_clk), .o_bus(bus),
    .i_lb_rdata(rdata), .i_lb_rvalid(rvalid));

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    i_fpsc_bridge_model.rd(a, got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t reg %h got %h exp %h", $time, a, got, exp);
    end
  endtask

  task automatic chk_pin(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t pin %s got %h exp %h", $time, nm, got, exp);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    i_fpsc_bridge_model.wr(a, d);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  // 0 start, 1 abort, 2 phase done, 3 over range: one-cycle pulses
  task automatic pulse(input int k);
    @(negedge i_sys_clk);
    {start, abort, ph_done, over_range} = 4'h8 >> k;
    @(negedge i_sys_clk);
    {start, abort, ph_done, over_range} = 4'h0;
  endtask

  task automatic push(input logic [31:0] d, input logic last);
    @(negedge i_sys_clk);
    dp = '{valid: 1'h1, last: last, data: d};
    @(negedge i_sys_clk);
    dp = '{valid: 1'h0, last: 1'h0, data: ~d};
  endtask

  task automatic t_reset;
    chk_pin("smp_rst", smp_rst, 1);
    chk_reg(8'h18, 32'hffff_ffff);
    chk_reg(8'h1c, 32'h0);
    chk_reg(8'h24, 32'h0001_0000);
    chk_reg(8'h28, 32'h0);
    chk_reg(8'h2c, 32'h0);
    chk_reg(8'h30, 32'h0);
    chk_reg(8'h38, 32'h0);
    chk_reg(8'h3c, 32'h7f);
    chk_reg(8'h34, 32'h5);
    chk_reg(8'h40, 32'h0);
    chk_pin("src", clk_src, 1);
    chk_pin("div", div, 7);
    chk_pin("intlv", non_int, 1);
    cyc(40);
    chk_pin("smp_rst", smp_rst, 0);
    $display("test reset done");
  endtask

  task automatic t_regs;
    w(8'h28, 32'hffff_ffff);
    chk_reg(8'h28, 32'h00ff_ffff);
    w(8'h38, 32'hffff_ffff);
    chk_reg(8'h38, 32'h00ff_ffff);
    w(8'h24, 32'h0);
    chk_reg(8'h24, 32'h0001_0000);
    w(8'h2c, 32'hffff_ffff);
    chk_reg(8'h2c, 32'h0);
    w(8'h3c, 32'h8e);
    chk_reg(8'h3c, 32'hde);
    chk_pin("smp_rst", smp_rst, 1);
    chk_pin("src", clk_src, 0);
    chk_pin("intlv", non_int, 0);
    for (int c = 7; c >= 3; c--)
    begin
      w(8'h3c, {24'h0, 4'ha, 3'(c), 1'h1});
      cyc(1);
      chk_pin("div", div, c);
      w(8'h3c, {24'h0, 4'h2, 3'(c), 1'h1});
      cyc(1);
      chk_pin("smp_rst", smp_rst, 0);
    end
    chk_reg(8'h3c, 32'h77);
    clk_ok = 3'h2;
    chk_reg(8'h34, 32'h2);
    $display("test registers done");
  endtask

  task automatic t_fifo;
    chk_pin("ready", dp_ready, 1);
    push(32'h1111_1111, 1'h0);
    push(32'h2222_2222, 1'h0);
    chk_pin("ready", dp_ready, 0);
    push(32'h3333_3333, 1'h0);
    chk_reg(8'h24, 32'h0);
    chk_reg(8'h1c, 32'h44);
    chk_pin("irq_n", irq_n, 1);
    chk_reg(8'h80, 32'h1111_1111);
    chk_reg(8'h80, 32'h2222_2222);
    chk_reg(8'h80, 32'h0);
    chk_reg(8'h24, 32'h0001_0000);
    chk_reg(8'h1c, 32'h64);
    w(8'h1c, 32'h0);
    chk_reg(8'h1c, 32'h64);
    w(8'h1c, 32'h24);
    chk_reg(8'h1c, 32'h40);
    $display("test fifo done");
  endtask

  task automatic t_irq;
    w(8'h18, 32'h0);
    chk_reg(8'h18, 32'hffff_fe98);
    chk_pin("irq_n", irq_n, 0);
    w(8'h1c, 32'hffff_ffff);
    cyc(2);
    chk_pin("irq_n", irq_n, 1);
    chk_reg(8'h80, 32'h0);
    cyc(2);
    chk_pin("irq_n", irq_n, 0);
    w(8'h1c, 32'h0);
    chk_pin("irq_n", irq_n, 1);
    cyc(2);
    chk_pin("irq_n", irq_n, 0);
    w(8'h1c, 32'h20);
    cyc(2);
    chk_pin("irq_n", irq_n, 1);
    pulse(3);
    cyc(2);
    chk_pin("irq_n", irq_n, 0);
    chk_reg(8'h1c, 32'h100);
    w(8'h1c, 32'h100);
    w(8'h18, 32'hffff_ffff);
    $display("test interrupt done");
  endtask

  task automatic t_seq;
    w(8'h28, 32'h1);
    w(8'h38, 32'h1);
    w(8'h1c, 32'hffff_ffff);
    pulse(0);
    chk_pin("active", active, 1);
    chk_reg(8'h2c, 32'h0500_0001);
    chk_reg(8'h30, 32'h1);
    mode = 7'h09;
    w(8'h28, 32'h2);
    chk_reg(8'h30, 32'h1);
    chk_reg(8'h2c, 32'h0500_0001);
    pulse(2);
    chk_reg(8'h30, 32'h0);
    chk_reg(8'h1c, 32'h2);
    pulse(2);
    cyc(3);
    chk_reg(8'h1c, 32'h2);
    push(32'h5555_5555, 1'h1);
    chk_reg(8'h1c, 32'h7);
    chk_reg(8'h2c, 32'h0900_0000);
    chk_reg(8'h30, 32'h2);
    chk_reg(8'h80, 32'h5555_5555);
    w(8'h1c, 32'hffff_ffff);
    repeat (3) pulse(2);
    chk_pin("active", active, 1);
    push(32'h6666_6666, 1'h1);
    chk_pin("active", active, 0);
    chk_reg(8'h1c, 32'h7);
    chk_reg(8'h80, 32'h6666_6666);
    w(8'h38, 32'h5);
    pulse(0);
    chk_reg(8'h2c, 32'h0900_0005);
    pulse(1);
    chk_pin("active", active, 0);
    // capture mode: one phase of one cycle so the fifo cannot overflow
    mode = 7'h03;
    w(8'h28, 32'h0);
    w(8'h38, 32'h0);
    w(8'h1c, 32'hffff_ffff);
    pulse(0);
    pulse(2);
    chk_pin("active", active, 1);
    push(32'h7777_7777, 1'h1);
    chk_pin("active", active, 0);
    chk_reg(8'h1c, 32'h7);
    chk_reg(8'h2c, 32'h0300_0000);
    chk_reg(8'h80, 32'h7777_7777);
    $display("test sequencer done");
  endtask

  initial
  begin
    repeat (5) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_resetn = 1'h1;
    t_reset;
    t_regs;
    t_fifo;
    t_irq;
    t_seq;
    give_verdict;
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge i_sys_clk);
    failures++;
    give_verdict;
  end
endmodule
